// file: design/csl_ctl.sv
// Controller end of the codeword strobe link, plus the codeword FIFO used by both ends.
// Assumes CORE_CLK at 25 MHz from the shared reference and a plain register port.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none

// Synchronous FIFO, flip-flop storage, valid/ready on both sides
module csl_fifo
   import csl_pkg::*;
#(
   parameter int W     = CSL_CW_W,
   parameter int DEPTH = CSL_FIFO_DEPTH
)
(
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [W-1:0]               in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [W-1:0]                    out_data,
   output logic [$clog2(DEPTH+1)-1:0]      level
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH+1);

   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [CW-1:0] cnt_q;
   logic          push;
   logic          pop;

   // Honest flags from the fill level
   assign in_ready  = (cnt_q != CW'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_ptr_q];
   assign level     = cnt_q;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage write
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_q <= cnt_q + 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// Controller end: codeword sender and result collector
module csl_ctl
   import csl_pkg::*;
#(
   parameter int CW_W      = CSL_CW_W,
   parameter int STRB_PIN  = CSL_CMD_STROBE,
   parameter int VALID_PIN = CSL_CMD_VALID,
   parameter int CW_LSB    = CSL_CMD_CW_LSB
)
(
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   csl_link_if.ctl          LINK,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic [31:0]      RDATA
);
   localparam int LW = $clog2(CSL_FIFO_DEPTH+1);

   logic [CSL_CMD_PINS-1:0] cmd_q;
   logic [7:0]              div_q;
   logic [7:0]              div_cnt_q;
   logic                    slot_end;
   logic                    tx_push;
   logic                    tx_ready;
   logic                    tx_valid;
   logic [CW_W-1:0]         tx_data;
   logic [LW-1:0]           tx_level;
   logic                    drop_q;
   logic [CSL_RES_PINS-1:0] res_s1_q;
   logic [CSL_RES_PINS-1:0] res_s2_q;
   logic                    strb_prev_q;
   logic                    res_take;
   logic [CSL_CW_W-1:0]     result_q;
   logic                    res_new_q;
   logic                    res_read;

   // Codewords from software queue for the link
   assign tx_push = WR & (ADDR == CSL_CTL_CW);
   csl_fifo #(.W(CW_W), .DEPTH(CSL_FIFO_DEPTH)) u_tx_fifo
   (
      .clk       (CORE_CLK),
      .rst       (RST),
      .in_valid  (tx_push),
      .in_ready  (tx_ready),
      .in_data   (WDATA[CW_W-1:0]),
      .out_valid (tx_valid),
      .out_ready (slot_end),
      .out_data  (tx_data),
      .level     (tx_level)
   );

   // Slot divider: rate is 25 MHz over an integer, phase fixed by reset
   assign slot_end = (div_cnt_q >= div_q - 8'h01);
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         div_q     <= CSL_DIV_RST;
         div_cnt_q <= '0;
      end
      else
      begin
         if (WR && ADDR == CSL_CTL_DIV)
         begin
            div_q <= (WDATA[7:0] == 8'h00) ? 8'h01 : WDATA[7:0];
         end
         div_cnt_q <= slot_end ? '0 : div_cnt_q + 8'h01;
      end
   end

   // Command pins: strobe toggles each slot, valid only with a codeword
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         cmd_q <= '0;
      end
      else if (slot_end)
      begin
         cmd_q[STRB_PIN]          <= ~cmd_q[STRB_PIN];
         cmd_q[VALID_PIN]         <= tx_valid;
         cmd_q[CW_LSB +: CW_W]    <= tx_valid ? tx_data : '0;
      end
   end
   assign LINK.cmd_pin = cmd_q;

   // Dropped write flag: a drop beats a clear in the same cycle
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         drop_q <= 1'b0;
      end
      else if (tx_push && !tx_ready)
      begin
         drop_q <= 1'b1;
      end
      else if (WR && ADDR == CSL_CTL_STAT && WDATA[CSL_CSTAT_DROP])
      begin
         drop_q <= 1'b0;
      end
   end

   // Two-stage synchroniser on the result pins
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         res_s1_q    <= '0;
         res_s2_q    <= '0;
         strb_prev_q <= 1'b0;
      end
      else
      begin
         res_s1_q    <= LINK.res_pin;
         res_s2_q    <= res_s1_q;
         strb_prev_q <= res_s2_q[CSL_RES_STROBE];
      end
   end

   // One result per strobe transition when valid is high
   assign res_take = (res_s2_q[CSL_RES_STROBE] ^ strb_prev_q) & res_s2_q[CSL_RES_VALID_LO];
   assign res_read = RD & (ADDR == CSL_CTL_RES);
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         result_q  <= '0;
         res_new_q <= 1'b0;
      end
      else if (res_take)
      begin
         result_q  <= res_s2_q[CSL_RES_CW_LSB +: CSL_CW_W];
         res_new_q <= 1'b1;
      end
      else if (res_read)
      begin
         res_new_q <= 1'b0;
      end
   end

   // Read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         RDATA <= '0;
      end
      else
      begin
         RDATA <= '0;
         if (RD)
         begin
            unique case (ADDR)
               CSL_CTL_DIV: RDATA[7:0] <= div_q;
               CSL_CTL_RES:
               begin
                  RDATA[CSL_RES_NEW]      <= res_new_q;
                  RDATA[CSL_CW_W-1:0]     <= result_q;
               end
               CSL_CTL_STAT:
               begin
                  RDATA[CSL_CSTAT_DROP]          <= drop_q;
                  RDATA[CSL_CSTAT_FULL]          <= ~tx_ready;
                  RDATA[CSL_CSTAT_CNT_LSB +: LW] <= tx_level;
               end
               default:     RDATA <= '0;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: design/csl_dev.sv
// Instrument end of the codeword strobe link; the codeword FIFO lives with the controller end.
// Assumes CORE_CLK at 25 MHz from the shared reference and a plain register port.
//
// Operation
// - Link signals only flow sender to receiver
// - Strobe toggles at constant rate, defines slots
// - Strobe derived from shared reference clock
// - Valid high exactly in slots with codewords
// - Codeword width is a parameter
// - Controller never exceeds 50 MHz codeword rate
// - Lower rates are 50 MHz over integer
// - Reference-to-link delay identical every activation
// - Strobe and valid pins selectable by index
// - Mask and shift extract up to 10 bits
// - Result pin mapping fixed, all outputs driven
// - Valid on pin 0, copy on 14
// - Ten result bits on pins 10 to 1
// - Pins 13 to 11 reserved outputs
// - Result strobe toggles on pin 15
// - Output latch clock pin unused
`timescale 1ns/1ns
`default_nettype none

// Instrument end: codeword receiver and result sender
module csl_dev
   import csl_pkg::*;
#(
   parameter int CW_W     = CSL_CW_W,
   parameter int SLOT_CYC = CSL_SLOT_CYC
)
(
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   csl_link_if.dev          LINK,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic [31:0]      RDATA
);
   localparam int LW = $clog2(CSL_FIFO_DEPTH+1);
   localparam int SW = (SLOT_CYC > 1) ? $clog2(SLOT_CYC) : 1;

   logic [CSL_CMD_PINS-1:0] cmd_s1_q;
   logic [CSL_CMD_PINS-1:0] cmd_s2_q;
   logic                    strb_prev_q;
   logic                    strb_now;
   logic                    slot_edge;
   logic                    rx_push;
   logic [CW_W-1:0]         rx_cw;
   logic [4:0]              strb_idx_q;
   logic [4:0]              val_idx_q;
   logic [CW_W-1:0]         mask_q;
   logic [4:0]              shift_q;
   logic                    ovf_q;
   logic                    fifo_in_ready;
   logic                    fifo_out_valid;
   logic                    fifo_pop;
   logic [CW_W-1:0]         fifo_out_data;
   logic [LW-1:0]           fifo_level;
   logic [SW-1:0]           slot_cnt_q;
   logic                    slot_end;
   logic                    pend_q;
   logic [CSL_CW_W-1:0]     pend_cw_q;
   logic [CSL_RES_PINS-1:0] res_q;
   logic [CSL_RES_PINS-1:0] res_oe_q;

   // Two-stage synchroniser on the command pins; receive only, no latch clock pin
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         cmd_s1_q <= '0;
         cmd_s2_q <= '0;
      end
      else
      begin
         cmd_s1_q <= LINK.cmd_pin;
         cmd_s2_q <= cmd_s1_q;
      end
   end

   // Slot detection on either strobe transition, selected pins
   assign strb_now  = cmd_s2_q[strb_idx_q];
   assign slot_edge = strb_now ^ strb_prev_q;
   assign rx_push   = slot_edge & cmd_s2_q[val_idx_q];
   assign rx_cw     = CW_W'(cmd_s2_q >> shift_q) & mask_q;

   // Previous strobe level
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         strb_prev_q <= 1'b0;
      end
      else
      begin
         strb_prev_q <= strb_now;
      end
   end

   // Received codewords wait here for software
   csl_fifo #(.W(CW_W), .DEPTH(CSL_FIFO_DEPTH)) u_rx_fifo
   (
      .clk       (CORE_CLK),
      .rst       (RST),
      .in_valid  (rx_push),
      .in_ready  (fifo_in_ready),
      .in_data   (rx_cw),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data),
      .level     (fifo_level)
   );

   // Reading the data register pops one codeword
   assign fifo_pop = RD & (ADDR == CSL_DEV_RXDATA) & fifo_out_valid;

   // Configuration registers
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         strb_idx_q <= CSL_STRB_IDX_RST;
         val_idx_q  <= CSL_VAL_IDX_RST;
         mask_q     <= CW_W'(CSL_MASK_RST);
         shift_q    <= CSL_SHIFT_RST;
      end
      else if (WR)
      begin
         if (ADDR == CSL_DEV_CFG)
         begin
            strb_idx_q <= WDATA[CSL_CFG_STRB_LSB +: 5];
            val_idx_q  <= WDATA[CSL_CFG_VAL_LSB +: 5];
         end
         if (ADDR == CSL_DEV_MASK)
         begin
            mask_q <= WDATA[CW_W-1:0];
         end
         if (ADDR == CSL_DEV_SHIFT)
         begin
            shift_q <= WDATA[4:0];
         end
      end
   end

   // Overflow flag: a lost codeword beats a clear in the same cycle
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         ovf_q <= 1'b0;
      end
      else if (rx_push && !fifo_in_ready)
      begin
         ovf_q <= 1'b1;
      end
      else if (WR && ADDR == CSL_DEV_STAT && WDATA[CSL_STAT_OVF])
      begin
         ovf_q <= 1'b0;
      end
   end

   // Read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         RDATA <= '0;
      end
      else
      begin
         RDATA <= '0;
         if (RD)
         begin
            unique case (ADDR)
               CSL_DEV_CFG:
               begin
                  RDATA[CSL_CFG_STRB_LSB +: 5] <= strb_idx_q;
                  RDATA[CSL_CFG_VAL_LSB +: 5]  <= val_idx_q;
               end
               CSL_DEV_MASK:   RDATA[CW_W-1:0] <= mask_q;
               CSL_DEV_SHIFT:  RDATA[4:0] <= shift_q;
               CSL_DEV_RXDATA:
               begin
                  RDATA[CSL_RX_VALID] <= fifo_out_valid;
                  RDATA[CW_W-1:0]     <= fifo_out_valid ? fifo_out_data : '0;
               end
               CSL_DEV_STAT:
               begin
                  RDATA[CSL_STAT_OVF]             <= ovf_q;
                  RDATA[CSL_STAT_CNT_LSB +: LW]   <= fifo_level;
               end
               CSL_DEV_RESULT: RDATA[CSL_CW_W-1:0] <= pend_cw_q;
               default:        RDATA <= '0;
            endcase
         end
      end
   end

   // Slot divider with a fixed phase after every reset
   assign slot_end = (slot_cnt_q == SW'(SLOT_CYC-1));
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         slot_cnt_q <= '0;
      end
      else
      begin
         slot_cnt_q <= slot_end ? '0 : slot_cnt_q + 1'b1;
      end
   end

   // Pending result: a new write wins over the slot that consumes it
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         pend_q    <= 1'b0;
         pend_cw_q <= '0;
      end
      else if (WR && ADDR == CSL_DEV_RESULT)
      begin
         pend_q    <= 1'b1;
         pend_cw_q <= WDATA[CSL_CW_W-1:0];
      end
      else if (slot_end)
      begin
         pend_q <= 1'b0;
      end
   end

   // Result pins: fixed map, all driven from flops
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         res_q    <= '0;
         res_oe_q <= '1;
      end
      else
      begin
         res_oe_q <= '1;
         if (slot_end)
         begin
            res_q[CSL_RES_STROBE]   <= ~res_q[CSL_RES_STROBE];
            res_q[CSL_RES_VALID_LO] <= pend_q;
            res_q[CSL_RES_VALID_HI] <= pend_q;
            res_q[CSL_RES_CW_LSB +: CSL_CW_W] <= pend_q ? pend_cw_q : '0;
            res_q[CSL_RES_RSV_LSB +: CSL_RES_RSV_W] <= '0;
         end
      end
   end

   assign LINK.res_pin    = res_q;
   assign LINK.res_pin_oe = res_oe_q;
endmodule
`default_nettype wire

// file: pkg/csl_link_if.sv
// Link wires between the controller end and the instrument end.
// Command pins run controller to instrument, result pins instrument to controller.
`timescale 1ns/1ns
`default_nettype none
interface csl_link_if;
   import csl_pkg::*;
   logic [CSL_CMD_PINS-1:0] cmd_pin;
   logic [CSL_RES_PINS-1:0] res_pin;
   logic [CSL_RES_PINS-1:0] res_pin_oe;
   // Instrument end
   modport dev (input cmd_pin, output res_pin, output res_pin_oe);
   // Controller end
   modport ctl (output cmd_pin, input res_pin, input res_pin_oe);
endinterface
`default_nettype wire

// file: pkg/csl_pkg.sv
// Constants shared by both ends of the codeword strobe link.
// Assumes one 25 MHz core clock on each end, derived from the shared reference.
`default_nettype none
package csl_pkg;
   // Clock and link timing
   localparam int          CSL_CLK_MHZ       = 25;
   localparam int          CSL_MAX_CW_MHZ    = 50;
   localparam int          CSL_SLOT_CYC      = (CSL_CLK_MHZ + CSL_MAX_CW_MHZ - 1) / CSL_MAX_CW_MHZ;
   // Link widths and fixed result pin map
   localparam int          CSL_CMD_PINS      = 32;
   localparam int          CSL_RES_PINS      = 16;
   localparam int          CSL_CW_W          = 10;
   localparam int          CSL_FIFO_DEPTH    = 8;
   localparam int          CSL_RES_VALID_LO  = 0;
   localparam int          CSL_RES_CW_LSB    = 1;
   localparam int          CSL_RES_RSV_LSB   = 11;
   localparam int          CSL_RES_RSV_W     = 3;
   localparam int          CSL_RES_VALID_HI  = 14;
   localparam int          CSL_RES_STROBE    = 15;
   // Controller's default placement on the command pins
   localparam int          CSL_CMD_STROBE    = 15;
   localparam int          CSL_CMD_VALID     = 0;
   localparam int          CSL_CMD_CW_LSB    = 1;
   // Device register offsets
   localparam logic [7:0]  CSL_DEV_CFG       = 8'h00;
   localparam logic [7:0]  CSL_DEV_MASK      = 8'h04;
   localparam logic [7:0]  CSL_DEV_SHIFT     = 8'h08;
   localparam logic [7:0]  CSL_DEV_RXDATA    = 8'h0c;
   localparam logic [7:0]  CSL_DEV_STAT      = 8'h10;
   localparam logic [7:0]  CSL_DEV_RESULT    = 8'h14;
   // Device field positions
   localparam int          CSL_CFG_STRB_LSB  = 0;
   localparam int          CSL_CFG_VAL_LSB   = 8;
   localparam int          CSL_STAT_OVF      = 0;
   localparam int          CSL_STAT_CNT_LSB  = 8;
   localparam int          CSL_RX_VALID      = 31;
   // Device reset values
   localparam logic [4:0]  CSL_STRB_IDX_RST  = 5'h0f;
   localparam logic [4:0]  CSL_VAL_IDX_RST   = 5'h00;
   localparam logic [9:0]  CSL_MASK_RST      = 10'h3ff;
   localparam logic [4:0]  CSL_SHIFT_RST     = 5'h01;
   // Controller register offsets
   localparam logic [7:0]  CSL_CTL_CW        = 8'h00;
   localparam logic [7:0]  CSL_CTL_DIV       = 8'h04;
   localparam logic [7:0]  CSL_CTL_RES       = 8'h08;
   localparam logic [7:0]  CSL_CTL_STAT      = 8'h0c;
   // Controller field positions and reset values
   localparam int          CSL_RES_NEW       = 31;
   localparam int          CSL_CSTAT_DROP    = 0;
   localparam int          CSL_CSTAT_FULL    = 1;
   localparam int          CSL_CSTAT_CNT_LSB = 8;
   localparam logic [7:0]  CSL_DIV_RST       = 8'h01;
endpackage
`default_nettype wire

// file: verification/codeword_strobe_link_tb.sv
// Testbench: both link ends joined back to back, driven over their register ports.
// Assumes package, interface, design files and checker compiled first.
`timescale 1ns/1ns
`default_nettype none
module codeword_strobe_link_tb import csl_pkg::*;;
   logic        clk, rst, d_wr, d_rd, c_wr, c_rd, pd, pc;
   logic [7:0]  d_addr, c_addr;
   logic [31:0] d_wdata, c_wdata, d_rdata, c_rdata, cmd, e;
   logic [15:0] s;
   logic [9:0]  r;
   logic [9:0]  cw [10];
   logic [31:0] q [$];
   int          num_errors, tests_run, i, n;
   int          sh [4] = '{1, 2, 1, 1};
   logic [9:0]  mk [4] = '{10'h00f, 10'h3ff, 10'h3ff, 10'h3ff};
   logic [31:0] cf [4] = '{32'h0000000f, 32'h0000000f, 32'h0000140f, 32'h00000014};

   csl_link_if link ();
   csl_dev i_csl_dev (.CORE_CLK(clk), .RST(rst), .LINK(link), .ADDR(d_addr),
      .WDATA(d_wdata), .WR(d_wr), .RD(d_rd), .RDATA(d_rdata));
   csl_ctl i_csl_ctl (.CORE_CLK(clk), .RST(rst), .LINK(link), .ADDR(c_addr),
      .WDATA(c_wdata), .WR(c_wr), .RD(c_rd), .RDATA(c_rdata));
   csl_link_sva i_csl_link_sva (.CORE_CLK(clk), .RST(rst), .cmd_pin(link.cmd_pin),
      .res_pin(link.res_pin), .res_pin_oe(link.res_pin_oe));

   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Pseudo-random source
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      tests_run++;
      if (g !== x)
      begin
         num_errors++;
         $display("CHECK FAILED %0t %s got %h want %h", $time, m, g, x);
      end
   endtask

   // Verdict and end of run
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // One register access on either end; the strobe lasts one cycle
   task automatic acc(input logic dev, input logic wr, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      if (dev)
      begin
         d_addr <= a;
         d_wdata <= v;
         d_wr <= wr;
         d_rd <= !wr;
      end
      else
      begin
         c_addr <= a;
         c_wdata <= v;
         c_wr <= wr;
         c_rd <= !wr;
      end
      @(posedge clk);
      d_wr <= 1'b0;
      d_rd <= 1'b0;
      c_wr <= 1'b0;
      c_rd <= 1'b0;
   endtask

   // Read with the expected answer noted first
   task automatic rd(input logic dev, input logic [7:0] a, input logic [31:0] x);
      q.push_back(x);
      acc(dev, 1'b0, a, 32'h0);
   endtask

   // Measures cycles between two command strobe transitions
   task automatic gap(input int div);
      logic l;
      l = link.cmd_pin[CSL_CMD_STROBE];
      for (n = 0; link.cmd_pin[CSL_CMD_STROBE] === l && n < 600; n++)
         @(posedge clk);
      l = link.cmd_pin[CSL_CMD_STROBE];
      for (n = 0; link.cmd_pin[CSL_CMD_STROBE] === l && n < 600; n++)
         @(posedge clk);
      chk(n, div, "strobe period");
   endtask

   // Waits a bounded time for a valid pin to rise
   task automatic pin_wait(input logic res);
      for (n = 0; (res ? link.res_pin[0] : link.cmd_pin[0]) !== 1'b1 && n < 16; n++)
         @(posedge clk);
      if (n == 16)
         chk(0, 1, "valid never rose");
   endtask

   // Read answers matched to the oldest note
   always @(posedge clk)
   begin
      if (pd || pc)
      begin
         e = q.pop_front();
         chk(pd ? d_rdata : c_rdata, e, "read data");
      end
      pd <= d_rd;
      pc <= c_rd;
   end

   // Hang guard
   initial
   begin
      repeat (40000) @(posedge clk);
      num_errors++;
      $display("CHECK FAILED %0t timeout", $time);
      conclude();
   end

   // Main sequence
   initial
   begin
      {rst, d_wr, d_rd, c_wr, c_rd, pd, pc} = 7'h40;
      {d_addr, c_addr, d_wdata, c_wdata} = '0;
      s = 16'h001c;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(1, CSL_DEV_CFG, 32'h0000000f);
      rd(1, CSL_DEV_MASK, 32'h000003ff);
      rd(1, CSL_DEV_SHIFT, 32'h00000001);
      rd(0, CSL_CTL_DIV, 32'h00000001);
      rd(1, 8'hfc, 32'h0);
      rd(0, 8'hfc, 32'h0);
      $display("reset test done");
      acc(0, 1, CSL_CTL_DIV, 32'h000000c8);
      gap(200);
      for (i = 0; i < 10; i++)
      begin
         s = lfsr(s);
         cw[i] = s[9:0];
         acc(0, 1, CSL_CTL_CW, {22'h0, cw[i]});
      end
      rd(0, CSL_CTL_STAT, 32'h00000803);
      acc(0, 1, CSL_CTL_STAT, 32'h1);
      rd(0, CSL_CTL_STAT, 32'h00000802);
      repeat (1800) @(posedge clk);
      rd(1, CSL_DEV_STAT, 32'h00000800);
      rd(0, CSL_CTL_STAT, 32'h0);
      acc(0, 1, CSL_CTL_DIV, 32'h0);
      gap(1);
      rd(0, CSL_CTL_DIV, 32'h00000001);
      acc(0, 1, CSL_CTL_CW, 32'h155);
      repeat (10) @(posedge clk);
      rd(1, CSL_DEV_STAT, 32'h00000801);
      acc(1, 1, CSL_DEV_STAT, 32'h1);
      rd(1, CSL_DEV_STAT, 32'h00000800);
      for (i = 0; i < 8; i++)
         rd(1, CSL_DEV_RXDATA, {1'b1, 21'h0, cw[i]});
      rd(1, CSL_DEV_RXDATA, 32'h0);
      rd(1, CSL_DEV_STAT, 32'h0);
      $display("buffer test done");
      for (i = 0; i < 4; i++)
      begin
         acc(1, 1, CSL_DEV_SHIFT, sh[i]);
         acc(1, 1, CSL_DEV_MASK, {22'h0, mk[i]});
         acc(1, 1, CSL_DEV_CFG, cf[i]);
         s = lfsr(s);
         acc(0, 1, CSL_CTL_CW, {22'h0, s[9:0]});
         pin_wait(1'b0);
         chk({22'h0, link.cmd_pin[10:1]}, {22'h0, s[9:0]}, "codeword pins");
         cmd = ({21'h0, s[9:0], 1'b1} >> sh[i]) & {22'h0, mk[i]};
         repeat (6) @(posedge clk);
         rd(1, CSL_DEV_RXDATA, (i < 2) ? {1'b1, 21'h0, cmd[9:0]} : 32'h0);
         acc(1, 1, CSL_DEV_CFG, 32'h0000000f);
      end
      $display("placement test done");
      for (i = 0; i < 3; i++)
      begin
         s = lfsr(s);
         r = (i == 0) ? 10'h3ff : s[9:0];
         acc(1, 1, CSL_DEV_RESULT, {22'h0, r});
         pin_wait(1'b1);
         chk({22'h0, link.res_pin[10:1]}, {22'h0, r}, "result pins");
         repeat (6) @(posedge clk);
         rd(0, CSL_CTL_RES, {1'b1, 21'h0, r});
         rd(0, CSL_CTL_RES, {22'h0, r});
      end
      rd(1, CSL_DEV_RESULT, {22'h0, r});
      repeat (3) @(posedge clk);
      $display("result test done");
      conclude();
   end
endmodule
`default_nettype wire

// file: verification/csl_link_sva.sv
// Checker for the link wires between the two ends.
// Assumes default controller pin placement and a one-cycle device slot.
`timescale 1ns/1ns
`default_nettype none
module csl_link_sva import csl_pkg::*;
(
   input wire logic                    CORE_CLK,
   input wire logic                    RST,
   input wire logic [CSL_CMD_PINS-1:0] cmd_pin,
   input wire logic [CSL_RES_PINS-1:0] res_pin,
   input wire logic [CSL_RES_PINS-1:0] res_pin_oe
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   // Strobe transitions mark slot borders
   sequence s_cmd_edge;
      $changed(cmd_pin[CSL_CMD_STROBE]);
   endsequence
   sequence s_res_edge;
      $changed(res_pin[CSL_RES_STROBE]);
   endsequence

   // Fixed result pin map
   a_res_valid_copy: assert property (res_pin[CSL_RES_VALID_HI] == res_pin[CSL_RES_VALID_LO])
      else $error("result valid copy differs");
   a_res_rsv_zero: assert property (res_pin[CSL_RES_RSV_LSB +: CSL_RES_RSV_W] == '0)
      else $error("reserved result pins not zero");
   a_res_all_out: assert property (res_pin_oe == '1)
      else $error("result pin not driven");
   // Slot timing on both directions, unused command pins low
   a_res_strobe_rate: assert property (s_res_edge |=> s_res_edge)
      else $error("result strobe missed a slot");
   a_res_slot_hold: assert property ($changed(res_pin[10:0]) |-> s_res_edge)
      else $error("result changed inside a slot");
   a_cmd_slot_hold: assert property ($changed(cmd_pin[10:0]) |-> s_cmd_edge)
      else $error("codeword changed inside a slot");
   a_cmd_strobe_due: assert property (s_cmd_edge |-> ##[1:256] s_cmd_edge)
      else $error("command strobe stopped");
   a_cmd_spare_low: assert property (cmd_pin[31:16] == '0 && cmd_pin[14:11] == '0)
      else $error("unused command pin driven");
   a_link_start: assert property ($fell(RST) |-> ##[1:4] s_res_edge)
      else $error("result strobe late after reset");
endmodule
`default_nettype wire
